// ---- common/timer_unit_defines.vh ----
// constants for the general timer unit: register indexes, control fields, timing
// assumes a 16-bit register port with a 4-bit word index
`ifndef TIMER_UNIT_DEFINES_VH
`define TIMER_UNIT_DEFINES_VH
`define A_CORE      4'h0
`define A_AUX_LOW   4'h1
`define A_AUX_HIGH  4'h2
`define A_SEC_CORE  4'h3
`define A_SEC_AUX   4'h4
`define A_CAPTURE_RELOAD_REG    4'h5
`define A_CTL_CORE  4'h6
`define A_CTL_LOW   4'h7
`define A_CTL_HIGH  4'h8
`define A_CTL_SCORE 4'h9
`define A_CTL_SAUX  4'hA
`define A_FLAGS     4'hB
// control word fields
`define F_PRESC     2:0
`define F_MODE      4:3
`define F_RUN       5
`define F_DOWN      6
`define F_DIRPIN    7
`define F_FUNC      10:9
`define F_ALT       11
`define F_TRIG      13:12
`define F_OPT       14
// modes
`define M_TIMER     2'h0
`define M_GATED     2'h1
`define M_COUNTER   2'h2
`define M_INCR      2'h3
// auxiliary function
`define FN_NORMAL   2'h0
`define FN_CAPTURE  2'h1
`define FN_RELOAD   2'h2
// flag bits
`define FL_CAPTURE_RELOAD_REG   5
`define FL_CAP_LOW  6
`define FL_CAP_HIGH 7
// base divide, as log2 of system clock cycles per count
`define BASE_ONE    4'h2
`define BASE_TWO    4'h1
`define RST_CTL     16'h0000
`define RST_CNT     16'h0000
`endif

// ---- hdl/general_timer_unit.v ----
// five 16-bit timers in two groups with capture/reload and toggle latches
// assumes a single-cycle register master and asynchronous pins that are synchronised here
//
// Contract
// RULE1 - five 16-bit timers in two groups
// RULE2 - timers chain to a timer of same group
// RULE3 - group one has four selectable modes
// RULE4 - timer mode counts prescaled system clock
// RULE5 - counter mode counts input pin events
// RULE6 - gated mode counts while gate pin active
// RULE7 - group one counts at most every 4 cycles
// RULE8 - direction by software or direction pin
// RULE9 - quadrature decode from input and direction pins
// RULE10 - core latch toggles on wrap, drives pin
// RULE11 - core latch can clock auxiliary timers
// RULE12 - aux as capture/reload register stops counting
// RULE13 - capture core count on aux pin edge
// RULE14 - reload core on pin or latch transition
// RULE15 - two reloads on opposite edges make waveform
// RULE16 - group two counts at most every 2 cycles
// RULE17 - group two clocked by prescaler or pins
// RULE18 - second aux direction only from software
// RULE19 - second latch toggles, clocks aux, drives pin
// RULE20 - second core wrap clocks compare array, reloads
// RULE21 - capture second aux on pin, optional clear
// RULE22 - capture also from core input transitions
// RULE23 - timers wrap and raise sticky flags
// RULE24 - pins held stable long enough to sample
`include "timer_unit_defines.vh"
module general_timer_unit (
  input  wire        CLK,
  input  wire        RST,
  input  wire [3:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output wire [15:0] RDATA,
  input  wire        TIN_CORE,
  input  wire        TIN_AUX_LOW,
  input  wire        TIN_AUX_HIGH,
  input  wire        EUD_CORE,
  input  wire        EUD_AUX_LOW,
  input  wire        EUD_AUX_HIGH,
  input  wire        TIN_SEC_CORE,
  input  wire        TIN_SEC_AUX,
  input  wire        EUD_SEC_CORE,
  input  wire        CAPTURE_IN,
  output wire        CORE_TOGGLE_OUT,
  output wire        SECOND_TOGGLE_OUT,
  output wire        COMPARE_CLK_OUT
);

  reg  [15:0] cnt_r [0:4];
  reg  [15:0] ctl_r [0:4];
  reg  [15:0] capture_reload_reg_r;
  reg  [7:0]  flag_r;
  reg         core_tl_r;
  reg         sec_tl_r;
  reg         cmp_r;
  reg  [9:0]  pre_r;
  wire [9:0]  s2_r;
  wire [9:0]  s3_r;
  reg  [15:0] rdata_r;
  reg  [15:0] rd_mux;
  reg  [7:0]  flag_nxt;
  integer     k;
  integer     j;

  wire [9:0]  pin_raw;
  wire [9:0]  edg;
  wire [9:0]  rise;
  wire [4:0]  ev;
  wire [4:0]  up;
  wire [4:0]  ov;
  wire [15:0] step [0:4];
  wire [1:0]  rl_sel_low;
  wire [1:0]  rl_sel_high;
  wire        rl_low;
  wire        rl_high;
  wire        cap_low;
  wire        cap_high;
  wire        cap_fire;
  wire [15:0] c3;
  wire [15:0] c4;
  wire        wr_flags;

  // pins above 5 are group two; index 3..5 are direction pins of group one
  assign pin_raw = {CAPTURE_IN, EUD_SEC_CORE, TIN_SEC_AUX, TIN_SEC_CORE,
                    EUD_AUX_HIGH, EUD_AUX_LOW, EUD_CORE, TIN_AUX_HIGH, TIN_AUX_LOW, TIN_CORE};
  assign edg  = s2_r ^ s3_r;
  assign rise = s2_r & ~s3_r;

  // two flops before any logic reads a pin; a third keeps history for edges
  pin_sync #(
    .W (10)
  ) u_sync (
    .clk  (CLK),
    .rst  (RST),
    .pin  (pin_raw),                                                    // [RULE24]
    .lvl  (s2_r),
    .prev (s3_r)
  );

  // one count every 2^(base+presc) cycles; the base sets the top resolution
  function tick;
    input [9:0] pre;
    input [2:0] p;
    input [3:0] base;
    reg   [9:0] m;
    begin
      m = ~(10'h3ff << ({1'b0, p} + base));
      tick = &(pre | ~m);
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_one
      wire [15:0] c = ctl_r[i];
      // the core ignores the auxiliary function field
      wire        free = (i == 0) || (c[`F_FUNC] == `FN_NORMAL);     // [RULE12]
      wire        tk = tick(pre_r, c[`F_PRESC], `BASE_ONE);          // [RULE4] [RULE7]
      wire        lat = (i != 0) && c[`F_ALT];
      wire        src = lat ? ov[0] : rise[i];                         // [RULE5] [RULE11] [RULE2]
      wire        quad = edg[i] | edg[3+i];                            // [RULE9]
      reg         e;
      always @* begin
        case (c[`F_MODE])
          `M_TIMER:   e = tk;
          `M_GATED:   e = tk & (s2_r[i] ^ c[`F_OPT]);                 // [RULE6]
          `M_COUNTER: e = src;
          `M_INCR:    e = quad;
          default:    e = 1'b0;
        endcase
      end
      assign ev[i] = c[`F_RUN] & free & e;                             // [RULE3]
      // A leading B counts up: new A against old B
      assign up[i] = (c[`F_MODE] == `M_INCR) ? (s2_r[i] ^ s3_r[3+i]) :
                     ~(c[`F_DOWN] ^ (c[`F_DIRPIN] & s2_r[3+i]));       // [RULE8] [RULE9]
    end
  endgenerate

  assign c3 = ctl_r[3];
  assign c4 = ctl_r[4];

  reg e3;
  reg e4;
  always @* begin
    case (c3[`F_MODE])
      `M_TIMER: e3 = tick(pre_r, c3[`F_PRESC], `BASE_TWO);             // [RULE16] [RULE17]
      `M_GATED: e3 = tick(pre_r, c3[`F_PRESC], `BASE_TWO) & (s2_r[6] ^ c3[`F_OPT]);
      default:  e3 = rise[6];                                           // [RULE17]
    endcase
    case (c4[`F_MODE])
      `M_TIMER: e4 = tick(pre_r, c4[`F_PRESC], `BASE_TWO);             // [RULE16]
      `M_GATED: e4 = tick(pre_r, c4[`F_PRESC], `BASE_TWO) & s2_r[7];
      default:  e4 = c4[`F_ALT] ? ov[3] : rise[7];                     // [RULE19] [RULE2]
    endcase
  end

  assign ev[3] = c3[`F_RUN] & e3;
  assign ev[4] = c4[`F_RUN] & e4;
  assign up[3] = ~(c3[`F_DOWN] ^ (c3[`F_DIRPIN] & s2_r[8]));          // [RULE18]
  // the second aux has no direction pin, software alone decides
  assign up[4] = ~c4[`F_DOWN];                                          // [RULE18]

  generate
    for (i = 0; i < 5; i = i + 1) begin : g_step
      assign step[i] = up[i] ? cnt_r[i] + 16'h0001 : cnt_r[i] - 16'h0001;   // [RULE23]
      assign ov[i]   = ev[i] & (up[i] ? (cnt_r[i] == 16'hffff) : (cnt_r[i] == 16'h0000));
    end
  endgenerate

  // reload triggers: 0 pin edge, 1 latch rising, 2 latch falling, 3 either
  function rl_trig;
    input [1:0] sel;
    input       pin;
    input       o;
    input       tl;
    begin
      case (sel)
        2'h0:    rl_trig = pin;
        2'h1:    rl_trig = o & ~tl;
        2'h2:    rl_trig = o & tl;
        default: rl_trig = o;
      endcase
    end
  endfunction

  assign rl_sel_low  = ctl_r[1][`F_TRIG];
  assign rl_sel_high = ctl_r[2][`F_TRIG];
  assign rl_low   = (ctl_r[1][`F_FUNC] == `FN_RELOAD) &
                    rl_trig(rl_sel_low, rise[1], ov[0], core_tl_r);     // [RULE14]
  assign rl_high  = (ctl_r[2][`F_FUNC] == `FN_RELOAD) &
                    rl_trig(rl_sel_high, rise[2], ov[0], core_tl_r);    // [RULE14] [RULE15]
  assign cap_low  = (ctl_r[1][`F_FUNC] == `FN_CAPTURE) & rise[1];       // [RULE13]
  assign cap_high = (ctl_r[2][`F_FUNC] == `FN_CAPTURE) & rise[2];       // [RULE13]

  reg cap_src;
  always @* begin
    case (c4[`F_TRIG])
      2'h0:    cap_src = edg[9];                                        // [RULE21]
      2'h1:    cap_src = edg[0];                                        // [RULE22]
      2'h2:    cap_src = edg[3];                                        // [RULE22]
      default: cap_src = edg[0] | edg[3];                               // [RULE22]
    endcase
  end
  assign cap_fire = (c4[`F_FUNC] == `FN_CAPTURE) & cap_src;

  assign wr_flags = WR && (ADDR == `A_FLAGS);

  always @* begin
    // set wins over a software clear in the same cycle
    flag_nxt = wr_flags ? (flag_r & ~WDATA[7:0]) : flag_r;
    flag_nxt = flag_nxt | {cap_high, cap_low, cap_fire, ov};            // [RULE23]
  end

  always @* begin
    case (ADDR)
      `A_CORE:      rd_mux = cnt_r[0];
      `A_AUX_LOW:   rd_mux = cnt_r[1];
      `A_AUX_HIGH:  rd_mux = cnt_r[2];
      `A_SEC_CORE:  rd_mux = cnt_r[3];
      `A_SEC_AUX:   rd_mux = cnt_r[4];
      `A_CAPTURE_RELOAD_REG:    rd_mux = capture_reload_reg_r;
      `A_CTL_CORE:  rd_mux = ctl_r[0];
      `A_CTL_LOW:   rd_mux = ctl_r[1];
      `A_CTL_HIGH:  rd_mux = ctl_r[2];
      `A_CTL_SCORE: rd_mux = ctl_r[3];
      `A_CTL_SAUX:  rd_mux = ctl_r[4];
      `A_FLAGS:     rd_mux = {8'h00, flag_r};
      default:      rd_mux = 16'h0000;
    endcase
  end

  // one free-running divider, so ticks of every timer line up from reset
  always @(posedge CLK or posedge RST) begin
    if (RST)
      pre_r <= 10'h000;
    else
      pre_r <= pre_r + 10'h001;
  end

  // read data stand for one cycle after the strobe and are zero otherwise
  always @(posedge CLK or posedge RST) begin
    if (RST)
      rdata_r <= 16'h0000;
    else if (RD)
      rdata_r <= rd_mux;
    else
      rdata_r <= 16'h0000;
  end

  // flags stay set until software writes a one to them
  always @(posedge CLK or posedge RST) begin
    if (RST)
      flag_r <= 8'h00;
    else
      flag_r <= flag_nxt;
  end

  // control words take effect on the cycle after the write
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (j = 0; j < 5; j = j + 1)
        ctl_r[j] <= `RST_CTL;
    end else begin
      for (j = 0; j < 5; j = j + 1) begin
        if (WR && (ADDR == `A_CTL_CORE + j[3:0]))
          ctl_r[j] <= WDATA;
      end
    end
  end

  // latches and the compare pulse move with the wrapping count, never before it
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      core_tl_r <= 1'b0;
      sec_tl_r  <= 1'b0;
      cmp_r     <= 1'b0;
    end else begin
      cmp_r <= ov[3];                                                   // [RULE20]
      if (ov[0])
        core_tl_r <= ~core_tl_r;                                        // [RULE10]
      if (ov[3])
        sec_tl_r <= ~sec_tl_r;                                          // [RULE19]
    end
  end

  // all five counts live in one process so the array has a single driver
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (k = 0; k < 5; k = k + 1)
        cnt_r[k] <= `RST_CNT;
    end else begin
      // software writes win over hardware updates of a count
      if (WR && (ADDR == `A_CORE))
        cnt_r[0] <= WDATA;
      else if (rl_low)
        cnt_r[0] <= cnt_r[1];                                           // [RULE14]
      else if (rl_high)
        cnt_r[0] <= cnt_r[2];                                           // [RULE15]
      else if (ev[0])
        cnt_r[0] <= step[0];                                            // [RULE1]
      if (WR && (ADDR == `A_AUX_LOW))
        cnt_r[1] <= WDATA;
      else if (cap_low)
        cnt_r[1] <= cnt_r[0];                                           // [RULE13]
      else if (ev[1])
        cnt_r[1] <= step[1];
      if (WR && (ADDR == `A_AUX_HIGH))
        cnt_r[2] <= WDATA;
      else if (cap_high)
        cnt_r[2] <= cnt_r[0];                                           // [RULE13]
      else if (ev[2])
        cnt_r[2] <= step[2];
      if (WR && (ADDR == `A_SEC_CORE))
        cnt_r[3] <= WDATA;
      else if (ov[3] && c3[`F_ALT])
        cnt_r[3] <= capture_reload_reg_r;                                           // [RULE20]
      else if (ev[3])
        cnt_r[3] <= step[3];
      if (WR && (ADDR == `A_SEC_AUX))
        cnt_r[4] <= WDATA;
      else if (cap_fire && c4[`F_OPT])
        cnt_r[4] <= 16'h0000;                                           // [RULE21]
      else if (ev[4])
        cnt_r[4] <= step[4];
    end
  end

  // capture_reload_reg: a software write beats a capture in the same cycle
  always @(posedge CLK or posedge RST) begin
    if (RST)
      capture_reload_reg_r <= 16'h0000;
    else if (WR && (ADDR == `A_CAPTURE_RELOAD_REG))
      capture_reload_reg_r <= WDATA;
    else if (cap_fire)
      capture_reload_reg_r <= cnt_r[4];                                             // [RULE21]
  end

  assign RDATA             = rdata_r;
  assign CORE_TOGGLE_OUT   = core_tl_r;
  assign SECOND_TOGGLE_OUT = sec_tl_r;
  assign COMPARE_CLK_OUT   = cmp_r;

endmodule // general_timer_unit

// two-flop synchroniser plus one history stage for edge detection
module pin_sync #(
  parameter W = 10
) (
  input  wire [0:0]   clk,
  input  wire [0:0]   rst,
  input  wire [W-1:0] pin,
  output wire [W-1:0] lvl,
  output wire [W-1:0] prev
);
  reg  [W-1:0] s1_r;
  reg  [W-1:0] s2_r;
  reg  [W-1:0] s3_r;
  // only the second and third flops feed logic; the first may still be settling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign lvl  = s2_r;
  assign prev = s3_r;
endmodule // pin_sync

// ---- testbench/timer_unit_monitor.sv ----
// assertions on the register port and the toggle and compare outputs of the timer unit
// assumes it is bound to the top module and sees its ports only
`include "timer_unit_defines.vh"
module timer_unit_monitor (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        CORE_TOGGLE_OUT,
  input wire logic        SECOND_TOGGLE_OUT,
  input wire logic        COMPARE_CLK_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctl_r;
  logic        tog_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // shadow of the aux_low control word; bits 8 and 15 hold no field
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_r <= 16'h0000;
      tog_r <= 1'b0;
    end else begin
      if (WR && ADDR == `A_CTL_LOW)
        ctl_r <= WDATA;
      tog_r <= SECOND_TOGGLE_OUT;
    end
  end
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  AST_UNMAPPED_ZERO: assert property ($past(RD) && $past(ADDR) >= 4'hC |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  AST_CTL_READBACK: assert property ($past(RD) && $past(ADDR) == `A_CTL_LOW
    |-> (RDATA & 16'h7EFF) == (ctl_r & 16'h7EFF))
    else $error("control word read back wrong");
  AST_CORE_TOGGLE_GAP: assert property ($changed(CORE_TOGGLE_OUT) |=> $stable(CORE_TOGGLE_OUT) [*3])
    else $error("core latch toggled faster than four cycles");
  AST_SECOND_TOGGLE_GAP: assert property ($changed(SECOND_TOGGLE_OUT) |=> $stable(SECOND_TOGGLE_OUT))
    else $error("second latch toggled faster than two cycles");
  AST_COMPARE_ONE_CYCLE: assert property (COMPARE_CLK_OUT |=> !COMPARE_CLK_OUT)
    else $error("compare clock pulse longer than one cycle");
  AST_COMPARE_FOLLOWS: assert property ($changed(SECOND_TOGGLE_OUT) |-> ##[0:1] COMPARE_CLK_OUT)
    else $error("second wrap gave no compare clock");
  AST_COMPARE_CAUSE: assert property (COMPARE_CLK_OUT |-> SECOND_TOGGLE_OUT != tog_r)
    else $error("compare clock without second wrap");
  COV_COMPARE: cover property (COMPARE_CLK_OUT);
  COV_CORE_WRAP: cover property ($changed(CORE_TOGGLE_OUT));
  COV_UNMAPPED: cover property (RD && ADDR >= 4'hC);
endmodule // timer_unit_monitor

// ---- testbench/quad_encoder_model.sv ----
// quadrature position sensor driving an encoder pin pair
// assumes one step request at a time, issued while busy is low
module quad_encoder_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step,
  input  wire logic       rev,
  input  wire logic [3:0] hold,
  output logic            enc_a,
  output logic            enc_b,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  logic [3:0] cnt_r;
  assign enc_a = ph_r[0] ^ ph_r[1];
  assign enc_b = ph_r[1];
  assign busy  = cnt_r != 4'h0;
  // hold decides prompt or slow motion; pins never change within it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_r  <= 2'h0;
      cnt_r <= 4'h0;
    end else if (busy) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (step) begin
      ph_r  <= rev ? ph_r - 2'h1 : ph_r + 2'h1;
      cnt_r <= hold;
    end
  end
endmodule // quad_encoder_model

// ---- testbench/general_timer_unit_tb_top.sv ----
// self-checking bench: register map, pin counting, captures, wraps and encoder tracking
// assumes the monitor and the encoder model are compiled first
`include "timer_unit_defines.vh"
module general_timer_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        rd_d = 1'b0;
  logic [3:0]  pin_r = 4'h0;
  logic [3:0]  misc_r = 4'h0;
  logic        step_r = 1'b0;
  logic        rev_r = 1'b0;
  logic [3:0]  hold_r = 4'h2;
  logic [31:0] seed_r = 32'h3dc6_5b92;
  logic [15:0] v;
  logic [31:0] exp_q[$];
  wire  [15:0] rdata;
  wire         enc_a, enc_b, busy, tog_core, tog_sec, cmp_clk;
  int          n_cmp = 0;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n1, n2;
  always #5 clk = ~clk;
  general_timer_unit u_dut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata),
    .TIN_CORE(pin_r[0]), .TIN_AUX_LOW(pin_r[1]), .TIN_AUX_HIGH(enc_a), .EUD_CORE(pin_r[2]),
    .EUD_AUX_LOW(misc_r[0]), .EUD_AUX_HIGH(enc_b), .TIN_SEC_CORE(misc_r[1]), .TIN_SEC_AUX(misc_r[2]),
    .EUD_SEC_CORE(misc_r[3]), .CAPTURE_IN(pin_r[3]), .CORE_TOGGLE_OUT(tog_core),
    .SECOND_TOGGLE_OUT(tog_sec), .COMPARE_CLK_OUT(cmp_clk));
  quad_encoder_model u_enc (.clk(clk), .rst(rst), .step(step_r), .rev(rev_r), .hold(hold_r),
    .enc_a(enc_a), .enc_b(enc_b), .busy(busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] e, input logic [15:0] m);
    comparisons++;
    if ((got & m) !== (e & m)) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      pin_r[i] <= 1'b1;
      repeat (4) @(posedge clk);
      pin_r[i] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic steps(input int n, input logic r, input logic [3:0] h);
    rev_r <= r;
    hold_r <= h;
    repeat (n) begin
      step_r <= 1'b1;
      @(posedge clk);
      step_r <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic fin(input string s);
    repeat (2) @(posedge clk);
    $display("test %s finished", s);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read data land one cycle after the strobe; oldest note is the one due
  always @(posedge clk) begin
    rd_d <= rd_en;
    cyc <= cyc + 1;
    if (cmp_clk)
      n_cmp <= n_cmp + 1;
    if (rd_d) begin
      chk(rdata, exp_q[0][15:0], exp_q[0][31:16]);
      void'(exp_q.pop_front());
    end
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 16; a++)
      bus_rd(4'(a), 16'h0000, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      seed_r = lfsr(seed_r);
      bus_wr(`A_CTL_LOW, seed_r[15:0] & 16'h7EDF);
      bus_rd(`A_CTL_LOW, seed_r[15:0] & 16'h7EDF, 16'h7EFF);
    end
    fin("registers");
    bus_wr(`A_CTL_CORE, 16'h0030);
    pulse(0, 5);
    bus_rd(`A_CORE, 16'h0005, 16'hFFFF);
    bus_wr(`A_CTL_CORE, 16'h0070);
    pulse(0, 2);
    bus_rd(`A_CORE, 16'h0003, 16'hFFFF);
    bus_wr(`A_CTL_LOW, 16'h0220);
    pulse(1, 1);
    bus_rd(`A_AUX_LOW, 16'h0003, 16'hFFFF);
    repeat (20) @(posedge clk);
    bus_rd(`A_AUX_LOW, 16'h0003, 16'hFFFF);
    bus_rd(`A_FLAGS, 16'h0040, 16'h00FF);
    bus_wr(`A_FLAGS, 16'h00FF);
    bus_rd(`A_FLAGS, 16'h0000, 16'h00FF);
    fin("counter and capture");
    for (int s = 0; s < 3; s++) begin
      v = 16'h1111 * 16'(s + 1);
      bus_wr(`A_SEC_AUX, v);
      bus_wr(`A_CTL_SAUX, 16'h0200 | 16'(s << 12));
      pulse(s == 0 ? 3 : (s == 1 ? 0 : 2), 1);
      bus_rd(`A_CAPTURE_RELOAD_REG, v, 16'hFFFF);
    end
    bus_wr(`A_CTL_SAUX, 16'h4200);
    pulse(3, 1);
    bus_rd(`A_SEC_AUX, 16'h0000, 16'hFFFF);
    fin("second capture");
    bus_wr(`A_CORE, 16'hFFFE);
    bus_wr(`A_CTL_CORE, 16'h0020);
    bus_wr(`A_SEC_CORE, 16'hFFFE);
    bus_wr(`A_CTL_SCORE, 16'h0020);
    repeat (16) @(posedge clk);
    chk({14'h0000, tog_core, tog_sec}, 16'h0003, 16'hFFFF);
    chk(16'(n_cmp), 16'h0001, 16'hFFFF);
    bus_wr(`A_CTL_CORE, 16'h0000);
    bus_wr(`A_CTL_SCORE, 16'h0000);
    bus_rd(`A_FLAGS, 16'h0029, 16'h00FF);
    fin("wrap");
    bus_wr(`A_CTL_HIGH, 16'h0038);
    seed_r = lfsr(seed_r);
    n1 = seed_r[2:0] + 1;
    n2 = n1 + seed_r[5:4] + 1;
    steps(n1, 1'b0, 4'h2);
    steps(n2, 1'b1, 4'h9);
    bus_rd(`A_AUX_HIGH, 16'(n1 - n2), 16'hFFFF);
    bus_rd(`A_FLAGS, 16'h0004, 16'h0004);
    fin("encoder");
    report_and_stop();
  end
endmodule // general_timer_unit_tb_top
bind general_timer_unit timer_unit_monitor u_mon (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .CORE_TOGGLE_OUT(CORE_TOGGLE_OUT), .SECOND_TOGGLE_OUT(SECOND_TOGGLE_OUT),
  .COMPARE_CLK_OUT(COMPARE_CLK_OUT));
